// [root_hub_port_status_regs.sv]
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rh_port_cfg.svh"
module root_hub_port_status_regs #(
	parameter int NPORT = 2
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  trans_busy,
	input  wire logic [31:0] hw_status,
	input  wire logic [31:0] hw_change,
	output logic             irq
);
	typedef struct packed {
		logic [31:0] rdata;
		logic        rdy;
		logic        err;
		logic [7:0]  count;
		logic [9:0]  ist;
		logic [9:0]  imask;
		logic        irq;
	} top_s;

	top_s r_q;
	top_s r_d;

	port_event_if pe [NPORT] ();
	logic [9:0] evt;

	// ---------------------------------------------
	// port slots
	// ---------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : gen_port
			port_slot u_slot (
				.mclk       (mclk),
				.reset_n    (reset_n),
				.trans_busy (trans_busy[g]),
				.hw_status  (hw_status[16*g +: 16]),
				.hw_change  (hw_change[16*g +: 16]),
				.pe         (pe[g])
			);
			assign pe[g].wr_en = psel && penable && pwrite && r_q.rdy == 1'b0
				&& paddr == (`OFF_PORT1 + 12'(4*g));
			assign pe[g].wr_data = pwdata;
			assign evt[5*g +: 5] = hw_change[16*g +: 5];
		end
	endgenerate

	logic [31:0] port_rd [NPORT];
	generate
		for (g = 0; g < NPORT; g++) begin : gen_rd
			assign port_rd[g] = {pe[g].change, pe[g].status};
		end
	endgenerate

	// ---------------------------------------------
	// apb slave
	// ---------------------------------------------
	logic access;
	assign access = psel && penable && !r_q.rdy;

	always_comb begin
		r_d       = r_q;
		r_d.rdy   = access;
		r_d.err   = 1'b0;
		r_d.rdata = 32'h0000_0000;
		if (access && pwrite) begin
			case (paddr)
				`OFF_PORT1, `OFF_PORT2, `OFF_PORT3: ;
				`OFF_PORT_COUNT: r_d.count = pwdata[7:0];
				`OFF_IRQ_STATUS: r_d.ist = r_q.ist & ~pwdata[9:0];
				`OFF_IRQ_MASK:   r_d.imask = pwdata[9:0];
				default:         r_d.err = 1'b1;
			endcase
		end else if (access) begin
			case (paddr)
				`OFF_PORT1:
					if (r_q.count != 8'h00) r_d.rdata = port_rd[0];
				`OFF_PORT2:
					if (r_q.count >= 8'h02) r_d.rdata = port_rd[1];
				`OFF_PORT3:      r_d.rdata = 32'h0000_0000;
				`OFF_PORT_COUNT: r_d.rdata = {24'h000000, r_q.count};
				`OFF_IRQ_STATUS: r_d.rdata = {22'h000000, r_q.ist};
				`OFF_IRQ_MASK:   r_d.rdata = {22'h000000, r_q.imask};
				default:         r_d.err = 1'b1;
			endcase
		end
		r_d.ist = r_d.ist | evt;
		r_d.irq = |(r_d.ist & r_d.imask);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			r_q <= '{32'h0000_0000, 1'b0, 1'b0, `COUNT_RESET_VAL,
				10'h000, 10'h000, 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata  = r_q.rdata;
	assign pready  = r_q.rdy;
	assign pslverr = r_q.err;
	assign irq     = r_q.irq;
endmodule : root_hub_port_status_regs
`default_nettype wire

// [rh_port_cfg.svh]
`ifndef RH_PORT_CFG_SVH
`define RH_PORT_CFG_SVH

// register byte addresses
`define OFF_PORT1       12'h054
`define OFF_PORT2       12'h058
`define OFF_PORT3       12'h05C
`define OFF_PORT_COUNT  12'h048
`define OFF_IRQ_STATUS  12'h060
`define OFF_IRQ_MASK    12'h064

// port register field positions
`define BIT_CONN        0
`define BIT_ENABLE      1
`define BIT_SUSPEND     2
`define BIT_OVERCUR     3
`define BIT_RESET       4
`define BIT_POWER       8
`define BIT_LOWSPEED    9
`define BIT_CONN_CHG    16
`define BIT_EN_CHG      17
`define BIT_SUSP_CHG    18
`define BIT_OC_CHG      19
`define BIT_RST_CHG     20

// writable / readable masks
`define PORT_LOW_MASK   16'h031F
`define PORT_CHG_MASK   16'h001F

// reset values
`define PORT_RESET_VAL  32'h0000_0000
`define COUNT_RESET_VAL 8'h02

`endif

// [rh_port_pkg.sv]
package rh_port_pkg;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_HELD = 2'b01
	} wr_state_e;

	typedef logic [15:0] half_t;

endpackage : rh_port_pkg

// [port_event_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface port_event_if;
	logic [15:0] status;
	logic [15:0] change;
	logic        wr_en;
	logic [31:0] wr_data;
	logic        busy;

	modport ctrl (
		input  status,
		input  change,
		output wr_en,
		output wr_data,
		input  busy
	);
	modport port (
		output status,
		output change,
		input  wr_en,
		input  wr_data,
		output busy
	);
endinterface : port_event_if
`default_nettype wire

// [port_slot.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rh_port_cfg.svh"
module port_slot (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic             trans_busy,
	input  wire logic [15:0]      hw_status,
	input  wire logic [15:0]      hw_change,
	port_event_if.port            pe
);
	typedef struct packed {
		rh_port_pkg::wr_state_e st;
		logic [31:0]            held;
		logic [15:0]            ctrl;
		logic [15:0]            chg;
	} slot_s;

	slot_s cur_q;
	slot_s cur_d;
	logic  apply;
	logic [31:0] wv;

	always_comb begin
		cur_d = cur_q;
		apply = 1'b0;
		wv    = 32'h0000_0000;
		case (cur_q.st)
			rh_port_pkg::WR_IDLE: begin
				if (pe.wr_en && trans_busy) begin
					cur_d.held = pe.wr_data;
					cur_d.st   = rh_port_pkg::WR_HELD;
				end else if (pe.wr_en) begin
					apply = 1'b1;
					wv    = pe.wr_data;
				end
			end
			rh_port_pkg::WR_HELD: begin
				if (!trans_busy) begin
					apply     = 1'b1;
					wv        = cur_q.held;
					cur_d.st  = rh_port_pkg::WR_IDLE;
				end
			end
			default: cur_d.st = rh_port_pkg::WR_IDLE;
		endcase
		// write-one clears, set wins over clear
		if (apply) begin
			cur_d.ctrl = wv[15:0] & `PORT_LOW_MASK;
			cur_d.chg  = cur_q.chg & ~wv[31:16];
		end
		cur_d.chg = (cur_d.chg | hw_change) & `PORT_CHG_MASK;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cur_q <= '{rh_port_pkg::WR_IDLE, 32'h0000_0000,
				16'h0000, 16'h0000};
		end else begin
			cur_q <= cur_d;
		end
	end

	assign pe.status = (hw_status | cur_q.ctrl) & `PORT_LOW_MASK;
	assign pe.change = cur_q.chg;
	assign pe.busy   = (cur_q.st == rh_port_pkg::WR_HELD);
endmodule : port_slot
`default_nettype wire

// [usb_port_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module usb_port_dev (
	input  wire logic        mclk,
	output logic      [1:0]  trans_busy,
	output logic      [31:0] hw_status,
	output logic      [31:0] hw_change
);
	initial begin
		trans_busy = 2'h0;
		hw_status = 32'h0;
		hw_change = 32'h0;
	end
	// one-cycle change pulse on port p
	task evt(input int p, input logic [4:0] b);
		@(posedge mclk) hw_change[16*p+:5] <= b;
		@(posedge mclk) hw_change <= 32'h0;
	endtask : evt
	task busy(input int p, input logic v);
		@(posedge mclk) trans_busy[p] <= v;
	endtask : busy
endmodule : usb_port_dev
`default_nettype wire

// [rh_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module rh_port_chk (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [7:0] cnt_q;
	wire logic rd = psel && penable && pready && !pwrite;
	// shadow of the port count register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) cnt_q <= 8'h02;
		else if (psel && penable && !pready && pwrite && paddr == 12'h048)
			cnt_q <= pwdata[7:0];
	end
	sequence acc_s;
		psel && penable && !pready;
	endsequence
	answer_a: assert property (acc_s |=> pready ##1 !pready) else $error("late");
	ready_sel_a: assert property (pready |-> psel && penable) else $error("stray");
	err_pair_a: assert property (pslverr |-> pready) else $error("err alone");
	p3_zero_a: assert property (rd && paddr == 12'h05C |-> prdata == 32'h0) else $error("p3");
	p2_off_a: assert property (rd && paddr == 12'h058 && cnt_q == 8'h01 |-> prdata == 32'h0) else $error("p2");
	rsvd_zero_a: assert property (rd && paddr[11:4] == 8'h05 |-> (prdata & 32'hFFE0FCE0) == 32'h0) else $error("rsvd");
endmodule : rh_port_chk
bind root_hub_port_status_regs rh_port_chk chk_u (.mclk, .reset_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
`default_nettype wire

// [root_hub_port_status_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module root_hub_port_status_regs_tb;
	logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic irq, pready, pslverr, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	wire logic [1:0] trans_busy;
	wire logic [31:0] hw_status, hw_change;
	int n_errors = 0, n_tests = 0, cyc = 0;
	always #2 mclk = ~mclk;
	root_hub_port_status_regs dut_u (.mclk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .trans_busy, .hw_status,
		.hw_change, .irq);
	usb_port_dev dev_u (.mclk, .trans_busy, .hw_status, .hw_change);
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk) penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task chk(input string n, input logic [31:0] v, e);
		n_tests++;
		if (v !== e) begin
			n_errors++;
			$display("ERROR %s exp %h got %h", n, e, v);
		end
	endtask : chk
	task t_map;
		apb(0, 12'h054, 0); chk("p1", rd, 32'h0);
		apb(0, 12'h05C, 0); chk("p3", rd, 32'h0);
		apb(0, 12'h0F0, 0); chk("err", {31'h0, err}, 32'h1);
		$display("t_map done");
	endtask : t_map
	task t_w1c;
		dev_u.hw_status <= 32'h0200_0000;
		apb(0, 12'h058, 0); chk("p2", rd, 32'h0000_0200);
		apb(1, 12'h064, 1);
		dev_u.evt(0, 5'h01);
		repeat (3) @(posedge mclk);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1, 12'h054, 0); apb(0, 12'h054, 0); chk("keep", rd, 32'h1_0000);
		apb(1, 12'h054, 32'h1_0000); apb(0, 12'h054, 0); chk("clr", rd, 0);
		apb(1, 12'h060, 1);
		repeat (2) @(posedge mclk);
		chk("irq", {31'h0, irq}, 32'h0);
		$display("t_w1c done");
	endtask : t_w1c
	task t_defer;
		dev_u.busy(0, 1);
		apb(1, 12'h054, 32'h100); apb(0, 12'h054, 0); chk("held", rd, 0);
		dev_u.busy(0, 0);
		repeat (2) @(posedge mclk);
		apb(0, 12'h054, 0); chk("applied", rd, 32'h100);
		$display("t_defer done");
	endtask : t_defer
	task t_count;
		apb(1, 12'h048, 1); apb(0, 12'h058, 0); chk("n1p2", rd, 0);
		apb(0, 12'h05C, 0); chk("n1p3", rd, 0);
		apb(1, 12'h048, 2); apb(0, 12'h058, 0); chk("n2p2", rd, 32'h200);
		apb(0, 12'h054, 0); chk("n2p1", rd, 32'h100);
		apb(1, 12'h048, 0); apb(0, 12'h054, 0); chk("n0p1", rd, 0);
		apb(1, 12'h048, 2);
		$display("t_count done");
	endtask : t_count
	task finish_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : finish_test
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			finish_test;
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1;
		t_map; t_w1c; t_defer; t_count;
		finish_test;
	end
endmodule : root_hub_port_status_regs_tb
`default_nettype wire
